// ---- include/osc_pkg.sv ----
// package: offsets, field positions, reset values and counts of the oscillator control block
package osc_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] addr_main_osc_control  = 16'hffa2;
   localparam logic [15:0] addr_osc_stable_status = 16'hffa3;
   localparam logic [15:0] addr_osc_wait_select   = 16'hffa4;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int          hs_osc_stop_bit      = 7;
   localparam int          wait_sel_msb         = 2;
   localparam logic [7:0]  rst_main_osc_control = 8'h00;
   localparam logic [7:0]  rst_stable_status    = 8'h00;
   localparam logic [2:0]  rst_wait_select      = 3'h5;

   // ----------------------------------------------------------------
   // stabilization thresholds, in high-speed oscillator cycles
   // ----------------------------------------------------------------
   localparam int          cnt_w       = 17;
   localparam logic [16:0] cyc_2p11    = 17'h00800;
   localparam logic [16:0] cyc_2p13    = 17'h02000;
   localparam logic [16:0] cyc_2p14    = 17'h04000;
   localparam logic [16:0] cyc_2p15    = 17'h08000;
   localparam logic [16:0] cyc_2p16    = 17'h10000;

   // ----------------------------------------------------------------
   // cpu clock withheld after reset, in internal oscillator clocks
   // ----------------------------------------------------------------
   localparam logic [4:0]  cpu_hold_clocks = 5'h11;
   localparam real         int_osc_khz     = 240.0;

   typedef enum logic [1:0]
   {
      st_idle  = 2'b00,
      st_count = 2'b01,
      st_done  = 2'b10
   } stab_state_t;

   // wait length selected by the 3-bit code; unlisted codes fall back to the longest
   function automatic logic [16:0] wait_limit(input logic [2:0] code);
      case (code)
         3'h1:    wait_limit = cyc_2p11;
         3'h2:    wait_limit = cyc_2p13;
         3'h3:    wait_limit = cyc_2p14;
         3'h4:    wait_limit = cyc_2p15;
         default: wait_limit = cyc_2p16;
      endcase
   endfunction

endpackage

// ---- design/pin_sync.sv ----
// three-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
   parameter int width = 1
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);
   logic [width-1:0] s1_r;
   logic [width-1:0] s2_r;
   logic [width-1:0] s3_r;

   if (width < 1)
   begin : g_bad_width
      $error("pin_sync width must be at least 1");
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r     <= '0;
         s2_r     <= '0;
         s3_r     <= '0;
         sync_out <= '0;
      end
      else if (clk_en)
      begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // a change counts once stages two and three agree
         for (int i = 0; i < width; i++)
         begin
            if (s2_r[i] == s3_r[i])
               sync_out[i] <= s2_r[i];
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

// ---- design/cpu_clk_hold.sv ----
// counts internal oscillator ticks after reset and releases the cpu clock
`timescale 1ns/1ps
`default_nettype none
module cpu_clk_hold
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic clk_en,
   input  wire logic int_osc_tick,
   output logic      cpu_clk_run
);
   import osc_pkg::*;

   logic [4:0] hold_cnt_r;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_cnt_r  <= 5'h00;
         cpu_clk_run <= 1'b0;
      end
      else if (clk_en && int_osc_tick && !cpu_clk_run)
      begin
         if (hold_cnt_r == cpu_hold_clocks - 5'h01)
            cpu_clk_run <= 1'b1;
         else
            hold_cnt_r <= hold_cnt_r + 5'h01;
      end
   end
endmodule // cpu_clk_hold
`default_nettype wire

// ---- design/osc_stabilization_control.sv ----
// oscillator stop control, stabilization counter and wait select registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - hs_osc_stop bit high halts the high-speed oscillator, low runs it.
// - on subsystem clock hs_osc_stop is ignored; pcc stop bit stops oscillator.
// - status clears on reset, stop instruction, hs_osc_stop set, pcc stop set.
// - status bits set in order from shortest interval and stay set.
// - status register is read-only, readable by bit or byte.
// - wait code 1..5 selects 2^11..2^16 cycles; other codes forbidden (code stores them and waits 2^16 cycles).
// - wait select resets to 05h, the longest wait.
// - wait select accepts only whole byte writes.
// - wait enforced only for stop release on high-speed cpu clock.
// - after stop release counting ends at the selected wait.
// - stop release wait counts only after oscillation starts.
// - internal oscillator always runs after reset release.
// - option setting decides whether software may stop internal oscillator.
// - prescaler source follows the cpu clock selection.
// - cpu_clk_status reads 0 on internal clock, 1 on high-speed clock.
// - cpu clock withheld 17 internal oscillator clocks after reset.
module osc_stabilization_control
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   // register access port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_wr_bit,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // cpu clock state
   input  wire logic        cpu_clk_select,
   input  wire logic        cpu_on_subclk,
   input  wire logic        pcc_hs_osc_stop,
   input  wire logic        int_osc_stop_req,
   input  wire logic        int_osc_stoppable,
   // standby events
   input  wire logic        stop_enter,
   input  wire logic        stop_release,
   input  wire logic        hs_osc_running,
   input  wire logic        int_osc_tick,
   // outputs
   output logic             hs_osc_enable,
   output logic             int_osc_enable,
   output logic             cpu_clk_status,
   output logic             stop_wait_done,
   output logic             prescaler_src_hs,
   output logic             cpu_clk_run
);
   import osc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  osc_ctl_r;
   logic [2:0]  wait_sel_r;
   logic [4:0]  stable_r;
   logic [16:0] cnt_r;
   logic        cnt_limited_r;
   logic        osc_run_s;
   logic        hs_osc_stop;
   logic        hs_osc_off;
   logic        clear_evt;
   logic        stop_active_r;
   logic        wait_armed_r;
   logic        stop_r;
   logic        pcc_stop_r;
   logic [16:0] limit_w;
   stab_state_t state_r;

   assign hs_osc_stop = osc_ctl_r[hs_osc_stop_bit];
   assign limit_w     = cnt_limited_r ? wait_limit(wait_sel_r) : cyc_2p16;

   // oscillator start indication comes from the analog side
   pin_sync #(.width(1)) u_osc_sync
   (
      .clock    (clock),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .async_in (hs_osc_running),
      .sync_out (osc_run_s)
   );

   cpu_clk_hold u_hold
   (
      .clock        (clock),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .int_osc_tick (int_osc_tick),
      .cpu_clk_run  (cpu_clk_run)
   );

   // ----------------------------------------------------------------
   // oscillator control
   // ----------------------------------------------------------------
   // on subsystem clock only the pcc stop bit stops the oscillator
   always_comb
   begin
      if (cpu_on_subclk)
         hs_osc_off = pcc_hs_osc_stop;
      else
         hs_osc_off = hs_osc_stop || stop_active_r;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         osc_ctl_r <= rst_main_osc_control;
      end
      else if (clk_en && reg_wr && reg_addr == addr_main_osc_control && !cpu_on_subclk)
      begin
         osc_ctl_r <= {reg_wdata[hs_osc_stop_bit], 7'h00};
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hs_osc_enable    <= 1'b0;
         int_osc_enable   <= 1'b1;
         cpu_clk_status   <= 1'b0;
         prescaler_src_hs <= 1'b0;
      end
      else if (clk_en)
      begin
         hs_osc_enable    <= !hs_osc_off;
         // internal oscillator stops only if option allows and cpu not on it
         int_osc_enable   <= !(int_osc_stoppable && int_osc_stop_req
                               && (cpu_clk_status || cpu_on_subclk));
         cpu_clk_status   <= cpu_clk_select;
         prescaler_src_hs <= cpu_clk_select;
      end
   end

   // ----------------------------------------------------------------
   // wait select register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wait_sel_r <= rst_wait_select;
      end
      else if (clk_en && reg_wr && !reg_wr_bit && reg_addr == addr_osc_wait_select)
      begin
         wait_sel_r <= reg_wdata[wait_sel_msb:0];
      end
   end

   // ----------------------------------------------------------------
   // clear events
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_r     <= 1'b0;
         pcc_stop_r <= 1'b0;
      end
      else if (clk_en)
      begin
         stop_r     <= hs_osc_stop;
         pcc_stop_r <= pcc_hs_osc_stop;
      end
   end

   // rising edges of the stop controls and the stop instruction clear status
   assign clear_evt = stop_enter || (hs_osc_stop && !stop_r)
                      || (pcc_hs_osc_stop && !pcc_stop_r);

   // ----------------------------------------------------------------
   // stabilization counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_active_r <= 1'b0;
         wait_armed_r  <= 1'b0;
         cnt_limited_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (stop_enter)
            stop_active_r <= 1'b1;
         else if (stop_release)
            stop_active_r <= 1'b0;
         if (stop_release && stop_active_r)
         begin
            cnt_limited_r <= 1'b1;
            wait_armed_r  <= cpu_clk_select;
         end
         else if (clear_evt)
         begin
            cnt_limited_r <= 1'b0;
            wait_armed_r  <= 1'b0;
         end
         else if (state_r == st_done)
         begin
            wait_armed_r  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= st_idle;
         cnt_r   <= '0;
      end
      else if (clk_en)
      begin
         case (state_r)
            st_idle:
            begin
               cnt_r <= '0;
               if (hs_osc_enable && osc_run_s && !clear_evt)
                  state_r <= st_count;
            end
            st_count:
            begin
               if (clear_evt || !hs_osc_enable)
               begin
                  state_r <= st_idle;
                  cnt_r   <= '0;
               end
               else if (cnt_r + 17'h00001 >= limit_w)
               begin
                  cnt_r   <= limit_w;
                  state_r <= st_done;
               end
               else
               begin
                  cnt_r <= cnt_r + 17'h00001;
               end
            end
            st_done:
            begin
               if (clear_evt || !hs_osc_enable)
               begin
                  state_r <= st_idle;
                  cnt_r   <= '0;
               end
            end
            default:
            begin
               state_r <= st_idle;
               cnt_r   <= '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status register and wait done
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stable_r       <= rst_stable_status[4:0];
         stop_wait_done <= 1'b0;
      end
      else if (clk_en)
      begin
         if (clear_evt || state_r == st_idle)
         begin
            stable_r <= 5'h00;
         end
         else
         begin
            // thermometer code: bit 4 shortest interval, bits only set
            stable_r <= stable_r | {cnt_r >= cyc_2p11, cnt_r >= cyc_2p13,
                                    cnt_r >= cyc_2p14, cnt_r >= cyc_2p15,
                                    cnt_r >= cyc_2p16};
         end
         stop_wait_done <= wait_armed_r && state_r == st_done;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= 8'h00;
      end
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            addr_main_osc_control:  reg_rdata <= osc_ctl_r;
            addr_osc_stable_status: reg_rdata <= {3'h0, stable_r};
            addr_osc_wait_select:   reg_rdata <= {5'h00, wait_sel_r};
            default:                reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule // osc_stabilization_control
`default_nettype wire

// ---- tb/osc_stabilization_control_sva.sv ----
// checker: port assertions of the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module osc_stab_check
   import osc_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        cpu_clk_select,
   input wire logic        cpu_on_subclk,
   input wire logic        pcc_hs_osc_stop,
   input wire logic        int_osc_stoppable,
   input wire logic        stop_release,
   input wire logic        hs_osc_running,
   input wire logic        int_osc_tick,
   input wire logic        hs_osc_enable,
   input wire logic        int_osc_enable,
   input wire logic        cpu_clk_status,
   input wire logic        stop_wait_done,
   input wire logic        cpu_clk_run
);
   // ----
   // helper counters
   // ----
   logic [4:0]  ticks_r;
   logic [16:0] run_r;
   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
         ticks_r <= 5'h00;
      else if (clk_en && int_osc_tick && ticks_r != 5'h1f)
         ticks_r <= ticks_r + 5'h01;
   // oscillating cycles since the last stop release
   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
         run_r <= 17'h00000;
      else if (clk_en && stop_release)
         run_r <= 17'h00000;
      else if (clk_en && hs_osc_enable && hs_osc_running && run_r != 17'h1ffff)
         run_r <= run_r + 17'h00001;
   // ----
   // assertions
   // ----
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_STATUS_THERMO:
   assert property (clk_en && reg_rd && reg_addr == addr_osc_stable_status
      |=> reg_rdata inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f}) else $error("status code");
   AST_WAIT_FIELD:
   assert property (clk_en && reg_rd && reg_addr == addr_osc_wait_select
      |=> reg_rdata[7:3] == 5'h00) else $error("wait select upper bits");
   AST_HS_OSC_STOP_HALT:
   assert property (clk_en && reg_wr && reg_addr == addr_main_osc_control && reg_wdata[7]
      && !cpu_on_subclk && !cpu_clk_status |-> ##[1:3] !hs_osc_enable) else $error("osc not halted");
   AST_PCC_HALT:
   assert property ($rose(pcc_hs_osc_stop) && cpu_on_subclk |-> ##[1:4] !hs_osc_enable)
      else $error("pcc stop ignored");
   AST_CPU_STATUS_INT:
   assert property ($fell(cpu_clk_select) |-> ##[1:8] !cpu_clk_status)
      else $error("cpu clock status stuck");
   AST_INT_OSC_KEEP:
   assert property ((!int_osc_stoppable)[*4] |-> int_osc_enable)
      else $error("internal oscillator stopped");
   AST_CPU_HOLD:
   assert property ($rose(cpu_clk_run) |-> ticks_r >= 5'h11) else $error("cpu clock early");
   AST_WAIT_DONE:
   assert property ($rose(stop_wait_done) |-> run_r >= cyc_2p11) else $error("wait done early");
endmodule // osc_stab_check

bind osc_stabilization_control osc_stab_check chk_u (.clock, .rst_b, .clk_en, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_clk_select, .cpu_on_subclk,
   .pcc_hs_osc_stop, .int_osc_stoppable, .stop_release, .hs_osc_running, .int_osc_tick,
   .hs_osc_enable, .int_osc_enable, .cpu_clk_status, .stop_wait_done, .cpu_clk_run);
`default_nettype wire

// ---- tb/osc_stabilization_control_tb.sv ----
// testbench: register and stabilization tests of the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module osc_stabilization_control_tb;
   import osc_pkg::*;
   // ----
   // stimulus and design
   // ----
   logic        clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        reg_wr = 1'b0, reg_wr_bit = 1'b0, reg_rd = 1'b0;
   logic        cpu_clk_select = 1'b0, cpu_on_subclk = 1'b0, pcc_hs_osc_stop = 1'b0;
   logic        int_osc_stop_req = 1'b0, int_osc_stoppable = 1'b0;
   logic        stop_enter = 1'b0, stop_release = 1'b0, hs_osc_running = 1'b1;
   logic        int_osc_tick = 1'b0;
   logic [1:0]  div = 2'h0;
   logic        hs_osc_enable, int_osc_enable, cpu_clk_status, stop_wait_done;
   logic        prescaler_src_hs, cpu_clk_run;
   int          n_errors = 0, samples_checked = 0, done_cnt = 0, d0;
   osc_stabilization_control dut_u (.clock, .rst_b, .clk_en, .reg_addr, .reg_wdata,
      .reg_wr, .reg_wr_bit, .reg_rd, .reg_rdata, .cpu_clk_select, .cpu_on_subclk,
      .pcc_hs_osc_stop, .int_osc_stop_req, .int_osc_stoppable, .stop_enter, .stop_release,
      .hs_osc_running, .int_osc_tick, .hs_osc_enable, .int_osc_enable, .cpu_clk_status,
      .stop_wait_done, .prescaler_src_hs, .cpu_clk_run);
   always #20 clock = ~clock;
   // internal oscillator tick every fourth cycle
   always @(posedge clock)
   begin
      div          <= div + 2'h1;
      int_osc_tick <= (div == 2'h3);
   end
   always @(posedge clock)
      if (stop_wait_done === 1'b1)
         done_cnt <= done_cnt + 1;
   // ----
   // access tasks
   // ----
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic c1(input string nm, input logic v, input logic e);
      #1 check(nm, {7'h00, v}, {7'h00, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
      @(posedge clock);
      reg_addr   <= a;
      reg_wdata  <= d;
      reg_wr     <= 1'b1;
      reg_wr_bit <= b;
      @(posedge clock);
      reg_wr     <= 1'b0;
      reg_wr_bit <= 1'b0;
   endtask
   task automatic rc(input string nm, input logic [15:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      #1 check(nm, reg_rdata, e);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial
   begin
      cyc(16);
      rst_b <= 1'b1;
      cyc(60);
      c1("cpu run held", cpu_clk_run, 1'b0);
      c1("int osc on", int_osc_enable, 1'b1);
      c1("hs osc on", hs_osc_enable, 1'b1);
      cyc(40);
      c1("cpu run", cpu_clk_run, 1'b1);
      rc("status", addr_osc_stable_status, 8'h00);
      rc("wait sel", addr_osc_wait_select, 8'h05);
      cyc(2000);
      rc("status", addr_osc_stable_status, 8'h10);
      $display("test reset done");
      c1("cpu clk status", cpu_clk_status, 1'b0);
      wr(addr_main_osc_control, 8'h80, 1'b0);
      cyc(4);
      c1("hs osc off", hs_osc_enable, 1'b0);
      rc("status", addr_osc_stable_status, 8'h00);
      rc("osc ctl", addr_main_osc_control, 8'h80);
      wr(addr_main_osc_control, 8'h00, 1'b0);
      cyc(4);
      c1("hs osc on", hs_osc_enable, 1'b1);
      cyc(2000);
      rc("status", addr_osc_stable_status, 8'h00);
      cyc(100);
      rc("status", addr_osc_stable_status, 8'h10);
      cyc(6050);
      rc("status", addr_osc_stable_status, 8'h10);
      cyc(100);
      rc("status", addr_osc_stable_status, 8'h18);
      $display("test count done");
      for (logic [7:0] k = 8'h01; k <= 8'h05; k++)
      begin
         wr(addr_osc_wait_select, k, 1'b0);
         rc("wait sel", addr_osc_wait_select, k);
      end
      wr(addr_osc_wait_select, 8'h03, 1'b1);
      rc("wait sel bit", addr_osc_wait_select, 8'h05);
      wr(addr_osc_wait_select, 8'h01, 1'b0);
      rc("wait sel", addr_osc_wait_select, 8'h01);
      $display("test wait select done");
      @(posedge clock) cpu_on_subclk <= 1'b1;
      wr(addr_main_osc_control, 8'h80, 1'b0);
      cyc(4);
      c1("hs osc subclk", hs_osc_enable, 1'b1);
      rc("osc ctl", addr_main_osc_control, 8'h00);
      @(posedge clock) pcc_hs_osc_stop <= 1'b1;
      cyc(6);
      c1("hs osc pcc", hs_osc_enable, 1'b0);
      rc("status", addr_osc_stable_status, 8'h00);
      @(posedge clock) pcc_hs_osc_stop <= 1'b0;
      @(posedge clock) cpu_on_subclk <= 1'b0;
      cyc(6);
      c1("hs osc on", hs_osc_enable, 1'b1);
      $display("test subclock done");
      cyc(2100);
      @(posedge clock) cpu_clk_select <= 1'b1;
      cyc(8);
      c1("cpu clk status", cpu_clk_status, 1'b1);
      c1("prescaler src", prescaler_src_hs, 1'b1);
      @(posedge clock) int_osc_stop_req <= 1'b1;
      cyc(8);
      c1("int osc locked", int_osc_enable, 1'b1);
      @(posedge clock) int_osc_stoppable <= 1'b1;
      cyc(8);
      c1("int osc stop", int_osc_enable, 1'b0);
      @(posedge clock) int_osc_stop_req <= 1'b0;
      cyc(8);
      c1("int osc run", int_osc_enable, 1'b1);
      @(posedge clock) int_osc_stoppable <= 1'b0;
      $display("test clock select done");
      @(posedge clock) stop_enter <= 1'b1;
      @(posedge clock) stop_enter <= 1'b0;
      hs_osc_running <= 1'b0;
      cyc(8);
      rc("status", addr_osc_stable_status, 8'h00);
      @(posedge clock) stop_release <= 1'b1;
      @(posedge clock) stop_release <= 1'b0;
      cyc(300);
      d0 = done_cnt;
      @(posedge clock) hs_osc_running <= 1'b1;
      cyc(2000);
      check("wait done early", (done_cnt != d0) ? 8'h01 : 8'h00, 8'h00);
      rc("status", addr_osc_stable_status, 8'h00);
      cyc(150);
      check("wait done", (done_cnt != d0) ? 8'h01 : 8'h00, 8'h01);
      rc("status", addr_osc_stable_status, 8'h10);
      cyc(6300);
      rc("status", addr_osc_stable_status, 8'h10);
      @(posedge clock) cpu_clk_select <= 1'b0;
      cyc(8);
      c1("cpu clk status", cpu_clk_status, 1'b0);
      c1("prescaler src", prescaler_src_hs, 1'b0);
      $display("test stop done");
      wr(addr_osc_stable_status, 8'hff, 1'b0);
      rc("status ro", addr_osc_stable_status, 8'h10);
      rc("unmapped", 16'hffa0, 8'h00);
      $display("test access done");
      rc("status", addr_osc_stable_status, 8'h10);
      wr(addr_osc_wait_select, 8'h02, 1'b0);
      d0 = done_cnt;
      @(posedge clock) stop_enter <= 1'b1;
      @(posedge clock) stop_enter <= 1'b0;
      @(posedge clock) stop_release <= 1'b1;
      @(posedge clock) stop_release <= 1'b0;
      cyc(8150);
      @(posedge clock) clk_en <= 1'b0;
      cyc(100);
      @(posedge clock) clk_en <= 1'b1;
      rc("status frozen", addr_osc_stable_status, 8'h10);
      cyc(8300);
      rc("status", addr_osc_stable_status, 8'h18);
      check("wait done internal", (done_cnt != d0) ? 8'h01 : 8'h00, 8'h00);
      $display("test internal stop done");
      give_verdict;
   end
   initial
   begin
      #2000000;
      n_errors++;
      give_verdict;
   end
endmodule // osc_stabilization_control_tb
`default_nettype wire
